// ===== include/ds3_e3_demap_pkg.sv
// shared constants, modes and helpers for the ds3/e3 drop-side demapper
package ds3_e3_demap_pkg;

    // ========
    // incoming sts-1 frame geometry
    localparam int SPE_COLS = 87;
    localparam int SPE_ROWS = 9;
    localparam logic [6:0] AU3_STUFF_COL_A = 7'h1d;
    localparam logic [6:0] AU3_STUFF_COL_B = 7'h3a;
    localparam logic [6:0] TUG3_DROP_COLS = 7'h02;

    // ========
    // ds3 row layout, byte index after the vc-3 poh byte
    localparam logic [6:0] DS3_C1_BYTE = 7'h02;
    localparam logic [6:0] DS3_I1_FIRST = 7'h03;
    localparam logic [6:0] DS3_I1_LAST = 7'h1b;
    localparam logic [6:0] DS3_C2_BYTE = 7'h1e;
    localparam logic [6:0] DS3_I2_FIRST = 7'h1f;
    localparam logic [6:0] DS3_I2_LAST = 7'h38;
    localparam logic [6:0] DS3_C3_BYTE = 7'h3b;
    localparam logic [6:0] DS3_I3_FIRST = 7'h3c;
    localparam logic [6:0] DS3_I3_LAST = 7'h55;
    localparam logic [7:0] DS3_C1_INFO_MASK = 8'h1f;
    localparam logic [7:0] DS3_S_MASK = 8'h01;
    localparam logic [2:0] STUFF_VOTE_MIN = 3'h3;

    // ========
    // e3 subframe layout, byte index after the vc-3 poh byte
    localparam logic [1:0] E3_SUB_ROWS = 2'h3;
    localparam logic [6:0] E3_CTRL_BYTE_A = 7'h00;
    localparam logic [6:0] E3_CTRL_BYTE_B = 7'h04;
    localparam logic [6:0] E3_S_BYTE = 7'h08;

    // ========
    // elastic store and output rate
    localparam int FIFO_DEPTH = 54;
    localparam int CLK_RATE_KHZ = 100000;
    localparam int DS3_RATE_KBPS = 44736;
    localparam int E3_RATE_KBPS = 34368;
    localparam logic [31:0] DS3_PHASE_INC = 32'((64'(DS3_RATE_KBPS) << 32) / 64'(CLK_RATE_KHZ));
    localparam logic [31:0] E3_PHASE_INC = 32'((64'(E3_RATE_KBPS) << 32) / 64'(CLK_RATE_KHZ));

    // ========
    // ds3 alarm frame geometry
    localparam logic [6:0] AIS_BLOCK_LAST = 7'h54;
    localparam logic [2:0] AIS_BLOCK_COUNT_LAST = 3'h7;
    localparam logic [2:0] AIS_SUBFRAME_LAST = 3'h6;

    // ========
    // event bits and output routing
    localparam int IRQ_W = 6;
    localparam int IRQ_SPE_INC = 0;
    localparam int IRQ_SPE_DEC = 1;
    localparam int IRQ_TU3_INC = 2;
    localparam int IRQ_TU3_DEC = 3;
    localparam int IRQ_FIFO_OVR = 4;
    localparam int IRQ_FIFO_UDR = 5;
    localparam logic [1:0] ROUTE_FRAMER = 2'h0;
    localparam logic [1:0] ROUTE_SYSBUS = 2'h1;
    localparam logic [1:0] ROUTE_M13 = 2'h2;

    typedef enum logic [3:0] {
        MODE_AU3_DS3 = 4'b0001,
        MODE_AU3_E3 = 4'b0010,
        MODE_TUG3_DS3 = 4'b0100,
        MODE_TUG3_E3 = 4'b1000
    } demap_mode_t;

    // ========
    // helpers
    function automatic logic [2:0] addTwo(input logic [2:0] v, input logic b1, input logic b0);
        return v + {2'h0, b1} + {2'h0, b0};
    endfunction : addTwo

    function automatic logic stuffVote(input logic [2:0] ones);
        return ones >= STUFF_VOTE_MIN;
    endfunction : stuffVote

    // ds3 alarm bit: overhead bit at index 0 of each 85-bit block, else 1010 data
    function automatic logic aisPattern(input logic [6:0] bitIdx, input logic [2:0] blk, input logic [2:0] sub);
        if (bitIdx != 7'h00) begin
            return bitIdx[0];
        end
        if (blk == 3'h0) begin
            return (sub <= 3'h1) || (sub == 3'h5);
        end
        if (blk[0]) begin
            return (blk == 3'h1) || (blk == 3'h7);
        end
        return 1'b0;
    endfunction : aisPattern

endpackage : ds3_e3_demap_pkg

// ===== include/stream_if.sv
// byte stream carrier with valid and ready between the demapper's own modules
interface stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface : stream_if

// ===== core/two_entry_buffer.sv
// two-entry skid buffer between the byte assembler and the elastic store
module two_entry_buffer #(
    parameter int W = 8
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic flush, // drop both entries
    stream_if.snk fillSide, // bytes in
    stream_if.src drainSide // bytes out
);
    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic [1:0] cnt;
    } buf_state_t;

    buf_state_t q;
    buf_state_t d;

    // ========
    // handshake straight from the fill count
    assign fillSide.ready = (q.cnt != 2'h2);
    assign drainSide.valid = (q.cnt != 2'h0);
    assign drainSide.data = q.e0;

    // pop shifts first so a push that pops the last entry in the same cycle lands in e0; a full buffer refuses pushes
    always_comb begin
        d = q;
        if (drainSide.valid && drainSide.ready) begin
            d.e0 = q.e1;
            d.cnt = q.cnt - 2'h1;
        end
        if (fillSide.valid && fillSide.ready) begin
            if (d.cnt == 2'h0) begin
                d.e0 = fillSide.data;
            end else begin
                d.e1 = fillSide.data;
            end
            d.cnt = d.cnt + 2'h1;
        end
        if (flush) begin
            d = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : two_entry_buffer

// ===== core/ds3_e3_vc3_demapper.sv
// drop-side demapper: sts-1 / tug3 bytes in, serial ds3 or e3 bits out
// Notes on behaviour
// - one independent lane; three copies per device
// - carriage bit plus payload type pick mode
// - latch pointer justification events for software
// - au3 drops two fixed stuff columns
// - tug3 drops poh column and pointer column
// - payload parse always on vc-3 bytes
// - ds3 row of vc-3 is own subframe
// - row gives info, control, opportunity, overhead
// - overhead channel bits never extracted
// - three of five ones makes stuff
// - fixed byte order inside each ds3 row
// - stream to framer, system bus or m13
// - ds3 output at 44.736 mbps nominal
// - e3 three-row subframes, two votes each
// - defect or force gives alarm payload
// - bytes into 54-byte store, irqs, reset
module ds3_e3_vc3_demapper #(
    parameter int DEPTH = ds3_e3_demap_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk, // system clock, 100 mhz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [7:0] speByte, // incoming sts-1 byte
    input wire logic speValid, // speByte carries an spe byte
    input wire logic speFrameStart, // this byte is row 0 column 0
    input wire logic speCarriageSelect, // 1 au3, 0 tug3
    input wire logic e3Select, // 1 e3, 0 ds3
    input wire logic speIncIn, // spe positive justification seen
    input wire logic speDecIn, // spe negative justification seen
    input wire logic tu3IncIn, // tu3 positive justification seen
    input wire logic tu3DecIn, // tu3 negative justification seen
    input wire logic sonetDefect, // upstream defect level
    input wire logic forceAlarmPayload, // force alarm payload
    input wire logic elasticFifoSoftReset, // clear store and pipe
    input wire logic [1:0] routeSelect, // secondary destination
    input wire logic [ds3_e3_demap_pkg::IRQ_W-1:0] irqAck, // write-one clear of events
    input wire logic [ds3_e3_demap_pkg::IRQ_W-1:0] irqMask, // 1 lets event reach blockIrq
    output logic recoveredSerialPayloadOut, // serial payload to framer
    output logic recoveredPayloadValid, // qualifies the bit above
    output logic systemTributaryBusBit, // copy to system bus
    output logic systemTributaryBusValid, // qualifies system bus copy
    output logic m13DemuxBit, // copy to m13 demux
    output logic m13DemuxValid, // qualifies m13 copy
    output logic [ds3_e3_demap_pkg::IRQ_W-1:0] irqStatus, // sticky event bits
    output logic elasticFifoOverflowIrq, // sticky overflow
    output logic elasticFifoUnderflowIrq, // sticky underflow
    output logic blockIrq, // masked or of events
    output logic [6:0] fifoLevel // bytes held in store
);
    import ds3_e3_demap_pkg::*;
    localparam int PW = $clog2(DEPTH);
    localparam int LW = 7;

    // whole lane state; copies of this module never share anything
    typedef struct packed {
        logic framed;
        logic [6:0] col;
        logic [3:0] row;
        logic [2:0] cVote;
        logic [2:0] c1Vote;
        logic [2:0] c2Vote;
        logic [7:0] asmAcc;
        logic [3:0] asmCnt;
        logic [7:0] wrByte;
        logic wrValid;
        logic [DEPTH-1:0][7:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [LW-1:0] level;
        logic [7:0] serReg;
        logic [2:0] serCnt;
        logic [31:0] phase;
        logic [6:0] aisBit;
        logic [2:0] aisBlk;
        logic [2:0] aisSub;
        logic outBit;
        logic outValid;
        logic [IRQ_W-1:0] irq;
    } lane_state_t;

    lane_state_t q;
    lane_state_t d;
    demap_mode_t mode;
    logic isAu3;
    logic isE3;

    stream_if #(.W(8)) fillPath();
    stream_if #(.W(8)) drainPath();

    // ========
    // mode decode
    always_comb begin
        unique case ({speCarriageSelect, e3Select})
            2'b10: mode = MODE_AU3_DS3;
            2'b11: mode = MODE_AU3_E3;
            2'b00: mode = MODE_TUG3_DS3;
            2'b01: mode = MODE_TUG3_E3;
        endcase
    end
    assign isAu3 = (mode == MODE_AU3_DS3) || (mode == MODE_AU3_E3);
    assign isE3 = (mode == MODE_AU3_E3) || (mode == MODE_TUG3_E3);

    // ========
    // skid buffer in front of the elastic store
    assign fillPath.data = q.wrByte;
    assign fillPath.valid = q.wrValid;
    assign drainPath.ready = (q.level < LW'(DEPTH)) && !elasticFifoSoftReset;

    two_entry_buffer #(.W(8)) u_skid (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .flush(elasticFifoSoftReset),
        .fillSide(fillPath),
        .drainSide(drainPath)
    );

    // ========
    // next-state logic of the lane
    always_comb begin
        logic [6:0] curCol;
        logic [3:0] curRow;
        logic [6:0] vcol;
        logic [6:0] k;
        logic inVc;
        logic [7:0] mask;
        logic [1:0] sr;
        logic [7:0] acc;
        logic [3:0] n;
        logic [32:0] sum;
        logic fifoWr;
        logic fifoRd;
        logic [7:0] rdByte;
        logic [IRQ_W-1:0] ev;
        curCol = speFrameStart ? 7'h00 : q.col;
        curRow = speFrameStart ? 4'h0 : q.row;
        vcol = 7'h00;
        k = 7'h00;
        inVc = 1'b0;
        mask = 8'h00;
        sr = 2'(curRow % 4'h3);
        acc = q.asmAcc;
        n = q.asmCnt;
        sum = 33'h0;
        fifoWr = 1'b0;
        fifoRd = 1'b0;
        rdByte = 8'h00;
        ev = '0;
        d = q;
        d.wrValid = 1'b0;
        d.outValid = 1'b0;

        // frame position; nothing counts before the first frame start
        if (speValid && (speFrameStart || q.framed)) begin
            d.framed = 1'b1;
            if (curCol == 7'(SPE_COLS - 1)) begin
                d.col = 7'h00;
                d.row = (curRow == 4'(SPE_ROWS - 1)) ? 4'h0 : curRow + 4'h1;
            end else begin
                d.col = curCol + 7'h01;
                d.row = curRow;
            end
            // strip the carriage down to the vc-3
            if (isAu3) begin
                inVc = (curCol != AU3_STUFF_COL_A) && (curCol != AU3_STUFF_COL_B);
                vcol = curCol - ((curCol > AU3_STUFF_COL_B) ? 7'h02 : (curCol > AU3_STUFF_COL_A) ? 7'h01 : 7'h00);
            end else begin
                inVc = curCol >= TUG3_DROP_COLS;
                vcol = curCol - TUG3_DROP_COLS;
            end
            // vc-3 poh byte carries no payload
            inVc = inVc && (vcol != 7'h00);
            k = vcol - 7'h01;
        end

        // payload parse on the vc-3 byte index
        if (inVc && !isE3) begin
            if (k == DS3_C1_BYTE) begin
                mask = DS3_C1_INFO_MASK;
                d.cVote = {2'h0, speByte[5]};
            end else if (k == DS3_C2_BYTE) begin
                d.cVote = addTwo(q.cVote, speByte[7], speByte[6]);
            end else if (k == DS3_C3_BYTE) begin
                // overhead channel pair and fixed bit stay masked off
                d.cVote = addTwo(q.cVote, speByte[7], speByte[6]);
                mask = stuffVote(d.cVote) ? 8'h00 : DS3_S_MASK;
            end else if ((k >= DS3_I1_FIRST && k <= DS3_I1_LAST) || (k >= DS3_I2_FIRST && k <= DS3_I2_LAST) ||
                         (k >= DS3_I3_FIRST && k <= DS3_I3_LAST)) begin
                mask = 8'hff;
            end
        end else if (inVc) begin
            if (k[1:0] != 2'h0) begin
                mask = 8'hff;
            end else if (k == E3_CTRL_BYTE_A && sr == 2'h0) begin
                d.c1Vote = {2'h0, speByte[1]};
                d.c2Vote = {2'h0, speByte[0]};
            end else if (k == E3_CTRL_BYTE_A || (k == E3_CTRL_BYTE_B && sr != E3_SUB_ROWS - 2'h1)) begin
                d.c1Vote = addTwo(q.c1Vote, speByte[1], 1'b0);
                d.c2Vote = addTwo(q.c2Vote, speByte[0], 1'b0);
            end else if (k == E3_S_BYTE && sr == E3_SUB_ROWS - 2'h1) begin
                mask = {6'h00, !stuffVote(q.c1Vote), !stuffVote(q.c2Vote)};
            end
        end

        // pack surviving bits msb first into bytes; stuff never enters
        for (int i = 7; i >= 0; i--) begin
            if (mask[i]) begin
                acc = {acc[6:0], speByte[i]};
                n = n + 4'h1;
                if (n == 4'h8) begin
                    d.wrByte = acc;
                    d.wrValid = 1'b1;
                    n = 4'h0;
                end
            end
        end
        d.asmAcc = acc;
        d.asmCnt = n;

        // incoming stream cannot stall, so a refused byte is lost
        if (q.wrValid && !fillPath.ready) begin
            ev[IRQ_FIFO_OVR] = 1'b1;
        end
        fifoWr = drainPath.valid && drainPath.ready;
        if (fifoWr) begin
            d.mem[q.wp] = drainPath.data;
            d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
        end

        // fixed-rate bit tick; rate tracking comes only from stuff decisions
        sum = {1'b0, q.phase} + {1'b0, (isE3 ? E3_PHASE_INC : DS3_PHASE_INC)};
        d.phase = sum[31:0];
        if (sum[32]) begin
            if (sonetDefect || forceAlarmPayload) begin
                d.outBit = isE3 ? 1'b1 : aisPattern(q.aisBit, q.aisBlk, q.aisSub);
                d.outValid = 1'b1;
                if (q.aisBit == AIS_BLOCK_LAST) begin
                    d.aisBit = 7'h00;
                    if (q.aisBlk == AIS_BLOCK_COUNT_LAST) begin
                        d.aisBlk = 3'h0;
                        d.aisSub = (q.aisSub == AIS_SUBFRAME_LAST) ? 3'h0 : q.aisSub + 3'h1;
                    end else begin
                        d.aisBlk = q.aisBlk + 3'h1;
                    end
                end else begin
                    d.aisBit = q.aisBit + 7'h01;
                end
            end else if (q.serCnt != 3'h0) begin
                d.outBit = q.serReg[7];
                d.serReg = {q.serReg[6:0], 1'b0};
                d.serCnt = q.serCnt - 3'h1;
                d.outValid = 1'b1;
            end else if (q.level != '0) begin
                rdByte = q.mem[q.rp];
                fifoRd = 1'b1;
                d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
                d.outBit = rdByte[7];
                d.serReg = {rdByte[6:0], 1'b0};
                d.serCnt = 3'h7;
                d.outValid = 1'b1;
            end else begin
                ev[IRQ_FIFO_UDR] = 1'b1;
            end
        end
        d.level = q.level + LW'(fifoWr) - LW'(fifoRd);

        // software clear of the store empties every stage behind it
        if (elasticFifoSoftReset) begin
            d.wp = '0;
            d.rp = '0;
            d.level = '0;
            d.serCnt = 3'h0;
            d.asmCnt = 4'h0;
            d.wrValid = 1'b0;
        end

        // sticky events; a new event beats a same-cycle acknowledge
        ev[IRQ_SPE_INC] = speIncIn;
        ev[IRQ_SPE_DEC] = speDecIn;
        ev[IRQ_TU3_INC] = tu3IncIn;
        ev[IRQ_TU3_DEC] = tu3DecIn;
        d.irq = (q.irq & ~irqAck) | ev;
    end

    // one register for the whole lane, independent per copy
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ========
    // outputs
    assign recoveredSerialPayloadOut = q.outBit;
    assign recoveredPayloadValid = q.outValid;
    assign systemTributaryBusBit = q.outBit;
    assign systemTributaryBusValid = q.outValid && (routeSelect == ROUTE_SYSBUS);
    assign m13DemuxBit = q.outBit;
    // m13 demux only makes sense on a ds3
    assign m13DemuxValid = q.outValid && (routeSelect == ROUTE_M13) && !isE3;
    assign irqStatus = q.irq;
    assign elasticFifoOverflowIrq = q.irq[IRQ_FIFO_OVR];
    assign elasticFifoUnderflowIrq = q.irq[IRQ_FIFO_UDR];
    assign blockIrq = |(q.irq & irqMask);
    assign fifoLevel = q.level;
endmodule : ds3_e3_vc3_demapper

// ===== sim/spe_source_model.sv
// upstream sts-1 byte source that sends whole frames on request
module spe_source_model (
    input wire logic clk,          // bench clock
    input wire logic au3,          // 1 au3 layout, 0 tug3
    input wire logic [4:0] gap,    // cycles between bytes
    input wire logic [7:0] cA,     // vc-3 byte 2
    input wire logic [7:0] cB,     // vc-3 byte 30
    input wire logic [7:0] cC,     // vc-3 byte 59
    input wire logic [7:0] target, // frames wanted
    output logic [7:0] speByte,    // byte lane
    output logic speValid,         // byte qualifier
    output logic speFrameStart,    // row 0 column 0
    output logic [7:0] frames      // frames sent
);
    int col = 0;
    int row = 0;
    int hold = 0;
    int k;
    initial begin
        speByte = 8'h00;
        speValid = 1'b0;
        speFrameStart = 1'b0;
        frames = 8'h00;
    end
    // ========
    // byte generator, changes only on the falling edge
    always @(negedge clk) begin
        speValid = 1'b0;
        speFrameStart = 1'b0;
        speByte = ~speByte; // idle lane toggles so no stale byte looks valid
        if (hold > 0) begin
            hold = hold - 1;
        end else if (frames != target) begin
            k = au3 ? col - 1 - int'(col > 29) - int'(col > 58) : col - 3;
            if (au3 ? (col == 29 || col == 58) : col < 2) k = -1; // dropped columns carry ones
            speByte = (k == 2) ? cA : (k == 30) ? cB : (k == 59) ? cC :
                ((k > 2 && k < 28) || (k > 30 && k < 57) || k > 59) ? 8'h00 : 8'hff;
            speValid = 1'b1;
            speFrameStart = (col == 0 && row == 0);
            hold = int'(gap) - 1;
            col = (col == 86) ? 0 : col + 1;
            if (col == 0) row = (row == 8) ? 0 : row + 1;
            if (col == 0 && row == 0) frames = frames + 8'h01;
        end
    end
endmodule : spe_source_model

// ===== sim/ds3_e3_vc3_demapper_asserts.sv
// port-level checker for the ds3/e3 drop-side demapper
module ds3_e3_vc3_demapper_asserts #(parameter int DEPTH = 54) (
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset
    input wire logic speIncIn, // in
    input wire logic tu3DecIn, // in
    input wire logic e3Select, // in
    input wire logic sonetDefect, // in
    input wire logic forceAlarmPayload, // in
    input wire logic elasticFifoSoftReset, // in
    input wire logic [1:0] routeSelect, // in
    input wire logic [ds3_e3_demap_pkg::IRQ_W-1:0] irqAck, // in
    input wire logic [ds3_e3_demap_pkg::IRQ_W-1:0] irqMask, // in
    input wire logic recoveredSerialPayloadOut, // out
    input wire logic recoveredPayloadValid, // out
    input wire logic systemTributaryBusBit, // out
    input wire logic systemTributaryBusValid, // out
    input wire logic m13DemuxBit, // out
    input wire logic m13DemuxValid, // out
    input wire logic [ds3_e3_demap_pkg::IRQ_W-1:0] irqStatus, // out
    input wire logic elasticFifoOverflowIrq, // out
    input wire logic elasticFifoUnderflowIrq, // out
    input wire logic blockIrq, // out
    input wire logic [6:0] fifoLevel // out
);
    import ds3_e3_demap_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ========
    // event bits that must still be set one cycle on
    logic [IRQ_W-1:0] keepQ;
    always_ff @(posedge ref_clk) begin
        keepQ <= rst_n ? (irqStatus & ~irqAck) : '0;
    end
    a_irq_sticky: assert property ((irqStatus & keepQ) == keepQ)
        else $error("event bit dropped without ack");
    a_spe_inc_set: assert property (speIncIn |=> irqStatus[IRQ_SPE_INC])
        else $error("spe increment not latched");
    a_tu3_dec_set: assert property (tu3DecIn |=> irqStatus[IRQ_TU3_DEC])
        else $error("tu3 decrement not latched");
    a_ack_clear: assert property (irqAck[IRQ_SPE_INC] && !speIncIn |=> !irqStatus[IRQ_SPE_INC])
        else $error("ack did not clear");
    a_block_mask: assert property (blockIrq == |(irqStatus & irqMask))
        else $error("block irq not masked or of events");
    a_fifo_irq: assert property (elasticFifoOverflowIrq == irqStatus[IRQ_FIFO_OVR] &&
        elasticFifoUnderflowIrq == irqStatus[IRQ_FIFO_UDR])
        else $error("store irq outputs disagree");
    a_level_bound: assert property (int'(fifoLevel) <= DEPTH)
        else $error("store level above depth");
    a_valid_pulse: assert property (recoveredPayloadValid |=> !recoveredPayloadValid)
        else $error("bit rate above line rate");
    a_e3_alarm: assert property ((e3Select && (forceAlarmPayload || sonetDefect)) [*3] ##0
        recoveredPayloadValid |-> recoveredSerialPayloadOut)
        else $error("e3 alarm bit not one");
    a_sysbus_route: assert property (routeSelect == ROUTE_SYSBUS && $stable(routeSelect) |->
        systemTributaryBusValid == recoveredPayloadValid && systemTributaryBusBit == recoveredSerialPayloadOut)
        else $error("system bus copy wrong");
    a_m13_copy: assert property (m13DemuxValid |-> recoveredPayloadValid && m13DemuxBit == recoveredSerialPayloadOut)
        else $error("m13 copy wrong");
    a_soft_clear: assert property (elasticFifoSoftReset ##1 elasticFifoSoftReset |-> fifoLevel == 7'h00)
        else $error("soft reset left bytes");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> irqStatus == '0 && fifoLevel == 7'h00)
        else $error("reset left state");
    c_inc: cover property (speIncIn);
    c_ovr: cover property ($rose(elasticFifoOverflowIrq));
    c_alarm: cover property (e3Select && forceAlarmPayload && recoveredPayloadValid);
endmodule : ds3_e3_vc3_demapper_asserts
bind ds3_e3_vc3_demapper ds3_e3_vc3_demapper_asserts #(.DEPTH(DEPTH)) u_ds3_e3_vc3_demapper_asserts (.*);

// ===== sim/testbench.sv
// self-checking bench for the ds3/e3 drop-side demapper
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ds3_e3_demap_pkg::*;
    // ========
    // signals; a small store makes overflow quick
    localparam int DEPTH = 8;
    typedef struct {logic au3; logic [7:0] a, b, c; logic [1:0] route; int ones;} row_t;
    // control bytes with 0, 2, 3 and 5 ones in the vote, s bit set in byte 59
    row_t rows[4] = '{'{1'b1, 8'hc0, 8'h3f, 8'h3f, 2'h0, 9}, '{1'b0, 8'hc0, 8'hff, 8'h3f, 2'h1, 9},
        '{1'b1, 8'he0, 8'hff, 8'h3f, 2'h2, 0}, '{1'b0, 8'he0, 8'hff, 8'hff, 2'h1, 0}};
    logic ref_clk = 1'b0, rst_n = 1'b0, au3 = 1'b1, e3Sel = 1'b0, defect = 1'b0, force1 = 1'b0, softRst = 1'b0;
    logic [3:0] pulses = 4'h0;
    logic [IRQ_W-1:0] irqAck = '0, irqMask = '0, irqStatus;
    logic [1:0] routeSel = 2'h0;
    logic [4:0] gap = 5'h10;
    logic [7:0] cA = 8'h00, cB = 8'h00, cC = 8'h00, target = 8'h00, frames, speByte;
    logic speValid, speFrameStart, serOut, serValid, blockIrq;
    logic [6:0] fifoLevel;
    int n_mismatch = 0, compares = 0, nBits = 0, nOnes = 0, cum = 0, cumOnes = 0, b0, o0;
    always #5 ref_clk = ~ref_clk;
    spe_source_model u_spe_source_model (.clk(ref_clk), .au3(au3), .gap(gap), .cA(cA), .cB(cB), .cC(cC),
        .target(target), .speByte(speByte), .speValid(speValid), .speFrameStart(speFrameStart), .frames(frames));
    ds3_e3_vc3_demapper #(.DEPTH(DEPTH)) u_ds3_e3_vc3_demapper (.ref_clk(ref_clk), .rst_n(rst_n),
        .speByte(speByte), .speValid(speValid), .speFrameStart(speFrameStart), .speCarriageSelect(au3),
        .e3Select(e3Sel), .speIncIn(pulses[0]), .speDecIn(pulses[1]), .tu3IncIn(pulses[2]), .tu3DecIn(pulses[3]),
        .sonetDefect(defect), .forceAlarmPayload(force1), .elasticFifoSoftReset(softRst), .routeSelect(routeSel),
        .irqAck(irqAck), .irqMask(irqMask), .recoveredSerialPayloadOut(serOut), .recoveredPayloadValid(serValid),
        .systemTributaryBusBit(), .systemTributaryBusValid(), .m13DemuxBit(), .m13DemuxValid(),
        .irqStatus(irqStatus), .elasticFifoOverflowIrq(), .elasticFifoUnderflowIrq(), .blockIrq(blockIrq),
        .fifoLevel(fifoLevel));
    // valid stands one cycle, so count it mid-cycle
    always @(negedge ref_clk) begin
        if (serValid === 1'b1) begin
            nBits++;
            nOnes += int'(serOut === 1'b1);
        end
    end
    // ========
    // tasks
    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : checkVal
    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cycles
    task automatic drive(input logic [3:0] p, input logic [IRQ_W-1:0] a);
        pulses = p;
        irqAck = a;
        cycles(1);
        pulses = 4'h0;
        irqAck = '0;
        cycles(1);
    endtask : drive
    // wait for the source, then for the store to drain and the last byte to shift out
    task automatic finishFrame();
        for (int n = 0; n < 20000 && frames != target; n++) @(negedge ref_clk);
        for (int n = 0; n < 4000 && fifoLevel != 7'h00; n++) @(negedge ref_clk);
        cycles(40);
        checkVal({frames, fifoLevel}, {target, 7'h00});
    endtask : finishFrame
    task automatic conclude();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // ========
    // main sequence
    initial begin
        cycles(12);
        checkVal({irqStatus, fifoLevel, serValid, blockIrq}, 32'h0);
        rst_n = 1'b1;
        for (int r = 0; r < 4; r++) begin // tu3 select stays with software
            {au3, cA, cB, cC, routeSel} = {rows[r].au3, rows[r].a, rows[r].b, rows[r].c, rows[r].route};
            target = target + 8'h01;
            finishFrame();
            cum += 5445 + rows[r].ones;
            cumOnes += rows[r].ones;
            checkVal(nBits, cum - cum % 8);
            checkVal(nOnes, cumOnes);
        end
        // pointer events: latch, mask, ack, then set beating a same-cycle ack
        for (int i = 0; i < 4; i++) begin
            irqMask = (i % 2 == 0) ? IRQ_W'(1 << i) : '0;
            drive(4'(1 << i), '0);
            checkVal({irqStatus[i], blockIrq}, {1'b1, 1'(i % 2 == 0)});
            drive(4'h0, IRQ_W'(1 << i));
            checkVal(irqStatus[i], 0);
            drive(4'(1 << i), IRQ_W'(1 << i));
            checkVal(irqStatus[i], 1);
            drive(4'h0, IRQ_W'(1 << i));
        end
        // e3 alarm by force, then by defect, while bytes keep flowing
        e3Sel = 1'b1;
        target = target + 8'h01;
        for (int a = 0; a < 2; a++) begin
            {force1, defect} = {1'(a == 0), 1'(a == 1)};
            cycles(6);
            {b0, o0} = {nBits, nOnes};
            cycles(300);
            checkVal(nOnes - o0, nBits - b0);
            checkVal(nBits - b0 > 100, 1);
        end
        {force1, defect, e3Sel} = 3'h0;
        finishFrame();
        // bytes every cycle overrun the store; soft reset empties it
        gap = 5'h01;
        target = target + 8'h01;
        cycles(300);
        checkVal(irqStatus[IRQ_FIFO_OVR], 1);
        drive(4'h0, '1);
        softRst = 1'b1;
        cycles(2);
        checkVal(fifoLevel, 0);
        softRst = 1'b0;
        finishFrame();
        checkVal(irqStatus[IRQ_FIFO_UDR], 1);
        conclude();
    end
    // watchdog well above the ~65000-cycle run
    initial begin
        #900000;
        n_mismatch++;
        conclude();
    end
endmodule : testbench
